// file: asd_core.sv
// alu, accumulator, status flags, multiplier, phase sequencer and fetch pipeline
`timescale 1ns/100ps

// Summary of operation
// RQ1: eight-bit alu doing add, subtract, shift and bitwise logic
// RQ2: arithmetic results are two's complement
// RQ3: one operand from accumulator, the other from any addressed file register
// RQ4: eight-bit accumulator holds working operand and result
// RQ5: carry, nibble carry, zero updated per operation; others leave them unchanged
// RQ6: in subtraction carry and nibble carry mean no borrow out
// RQ7: signed overflow looks only at result bits six and seven; the code compares the carry into bit seven with the carry out
// RQ8: unsigned eight by eight multiply gives full sixteen-bit product in one cycle
// RQ9: register-to-register move bypasses the accumulator
// RQ10: sixteen-bit instruction word fetched whole in one cycle
// RQ11: fetch and execute overlap; branches and table transfers take two cycles
// RQ12: program address reaches 64K words
// RQ13: on-chip program memory is 2K, 4K or 8K words by variant
// RQ14: internal, external or mixed execution; no code protection in mixed mode
// RQ15: program counter and accumulator readable and writable as data locations
// RQ16: any operation on any register, direct or indirect addressing alike
// RQ17: clock divided into four phases forming one instruction cycle
// RQ18: operand read in second phase, result written in fourth phase
// RQ19: zero flag set when affecting result is all zeros, else cleared
// RQ20: overflow set when carry into bit seven differs from carry out
module asd_core
    import asd_pkg::*;
#(
    parameter int ACC_ADDR = 8'h0A,
    parameter int PCL_ADDR = 8'h02,
    parameter int PCH_ADDR = 8'h03
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic srst_i,
    // configuration
    input wire logic [1:0] exec_mode_i,
    input wire logic [1:0] pmem_size_i,
    input wire logic code_protect_i,
    // instruction fetch
    input wire logic [INSTR_W-1:0] prog_data_i,
    output logic [PADDR_W-1:0] program_counter_o,
    output logic prog_ext_o,
    output logic protect_active_o,
    // decoded operation
    input wire logic [3:0] op_i,
    input wire logic [FADDR_W-1:0] src_addr_i,
    input wire logic [FADDR_W-1:0] dst_addr_i,
    input wire logic dest_acc_i,
    input wire logic two_cycle_i,
    input wire logic [PADDR_W-1:0] branch_target_i,
    // register file
    input wire logic [DATA_W-1:0] file_rdata_i,
    output logic [FADDR_W-1:0] file_addr_o,
    output logic file_rd_o,
    output logic file_we_o,
    output logic [DATA_W-1:0] file_wdata_o,
    // status and results
    output logic [DATA_W-1:0] accumulator_o,
    output logic carry_flag_o,
    output logic nibble_carry_flag_o,
    output logic zero_flag_o,
    output logic signed_overflow_flag_o,
    output logic [2*DATA_W-1:0] product_o,
    output logic [INSTR_W-1:0] instr_o,
    output logic [PHASE_W-1:0] phase_o
);
    logic [PHASE_W-1:0] phase_reg, phase_next;
    logic [PADDR_W-1:0] pc_reg, pc_next;
    logic [INSTR_W-1:0] ir_reg, ir_next, fetch_reg, fetch_next;
    logic flush_reg, flush_next;
    logic [DATA_W-1:0] accumulator_reg, accumulator_next;
    logic [DATA_W-1:0] operand_reg, operand_next;
    logic [DATA_W-1:0] result_reg, result_next;
    logic c_reg, c_next, dc_reg, dc_next, z_reg, z_next, ov_reg, ov_next;
    logic [2*DATA_W-1:0] prod_reg, prod_next;
    logic wr_pend_reg, wr_pend_next;
    logic [DATA_W-1:0] op_b;

    // one adder serves add and subtract; subtract feeds inverted operand and carry-in
    function automatic logic [DATA_W:0] add8(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b,
                                             input logic ci);
        add8 = {1'b0, a} + {1'b0, b} + {{DATA_W{1'b0}}, ci};
    endfunction

    function automatic logic [NIB_W:0] add4(input logic [NIB_W-1:0] a, input logic [NIB_W-1:0] b,
                                           input logic ci);
        add4 = {1'b0, a} + {1'b0, b} + {{NIB_W{1'b0}}, ci};
    endfunction

    // operands are widened first so the full sixteen-bit product survives
    function automatic logic [2*DATA_W-1:0] mul8(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
        mul8 = {{DATA_W{1'b0}}, a} * {{DATA_W{1'b0}}, b};
    endfunction

    function automatic logic [PADDR_W-1:0] pmem_limit(input logic [1:0] sz);
        if (sz == PM_2K) begin
            pmem_limit = PMEM_2K;
        end else if (sz == PM_4K) begin
            pmem_limit = PMEM_4K;
        end else begin
            pmem_limit = PMEM_8K;
        end
    endfunction

    // phase sequencer
    always_comb begin
        phase_next = phase_reg + 2'h1; // see RQ17
        // reset parks the sequencer at the fetch phase so the first cycle is a whole one
        if (srst_i) begin
            phase_next = PH_FETCH_LATCH;
        end
    end

    always_ff @(posedge mclk_i) begin
        phase_reg <= phase_next;
    end

    // fetch pipeline: pc advances in first phase, word latched in last phase
    always_comb begin
        pc_next = pc_reg;
        ir_next = ir_reg;
        fetch_next = fetch_reg;
        flush_next = flush_reg;
        if (phase_reg == PH_FETCH_LATCH) begin
            ir_next = flush_reg ? {INSTR_W{1'b0}} : fetch_reg; // see RQ11
            flush_next = 1'b0;
            pc_next = pc_reg + 16'h0001; // see RQ12
        end
        if (phase_reg == PH_RESULT_WRITE) begin
            fetch_next = prog_data_i; // see RQ10
            // a branch or a write to a pc byte leaves the prefetched word stale, so it is flushed
            if (two_cycle_i && !flush_reg) begin
                pc_next = branch_target_i; // see RQ11
                flush_next = 1'b1;
            end else if (wr_pend_reg && dst_addr_i == FADDR_W'(PCL_ADDR)) begin
                pc_next = {pc_reg[15:8], result_reg}; // see RQ15
                flush_next = 1'b1;
            end else if (wr_pend_reg && dst_addr_i == FADDR_W'(PCH_ADDR)) begin
                pc_next = {result_reg, pc_reg[7:0]}; // see RQ15
                flush_next = 1'b1;
            end
        end
        if (srst_i) begin
            pc_next = PC_RESET;
            ir_next = {INSTR_W{1'b0}};
            fetch_next = {INSTR_W{1'b0}};
            flush_next = 1'b1;
        end
    end

    always_ff @(posedge mclk_i) begin
        pc_reg <= pc_next;
        ir_reg <= ir_next;
        fetch_reg <= fetch_next;
        flush_reg <= flush_next;
    end

    // operand source: accumulator and pc read as data locations too
    // only these three locations are internal; every other address reaches the file
    always_comb begin
        if (src_addr_i == FADDR_W'(ACC_ADDR)) begin
            op_b = accumulator_reg; // see RQ15
        end else if (src_addr_i == FADDR_W'(PCL_ADDR)) begin
            op_b = pc_reg[7:0];
        end else if (src_addr_i == FADDR_W'(PCH_ADDR)) begin
            op_b = pc_reg[15:8];
        end else begin
            op_b = file_rdata_i; // see RQ16
        end
    end

    // alu datapath
    always_comb begin
        logic [DATA_W:0] sum;
        logic [NIB_W:0] nsum;
        logic [DATA_W-1:0] b_in;
        logic cin, arith;
        sum = '0;
        nsum = '0;
        b_in = operand_reg;
        cin = 1'b0;
        arith = 1'b0;
        accumulator_next = accumulator_reg;
        operand_next = operand_reg;
        result_next = result_reg;
        c_next = c_reg;
        dc_next = dc_reg;
        z_next = z_reg;
        ov_next = ov_reg;
        prod_next = prod_reg;
        wr_pend_next = wr_pend_reg;
        if (phase_reg == PH_OPERAND_READ) begin
            operand_next = op_b; // see RQ18
        end
        if (phase_reg == PH_EXECUTE) begin
            wr_pend_next = 1'b0;
            case (op_i)
                OP_ADD, OP_ADDC: begin
                    cin = (op_i == OP_ADDC) ? c_reg : 1'b0;
                    arith = 1'b1;
                end
                OP_SUB, OP_SUBB: begin
                    b_in = ~operand_reg; // see RQ2
                    cin = (op_i == OP_SUBB) ? c_reg : 1'b1;
                    arith = 1'b1;
                end
                default: begin
                end
            endcase
            sum = add8(accumulator_reg, b_in, cin); // see RQ3
            nsum = add4(accumulator_reg[NIB_W-1:0], b_in[NIB_W-1:0], cin);
            case (op_i)
                OP_ADD, OP_ADDC, OP_SUB, OP_SUBB: begin
                    result_next = sum[DATA_W-1:0]; // see RQ1
                    c_next = sum[DATA_W]; // see RQ6
                    dc_next = nsum[NIB_W]; // see RQ6
                end
                OP_AND: result_next = accumulator_reg & operand_reg;
                OP_IOR: result_next = accumulator_reg | operand_reg;
                OP_XOR: result_next = accumulator_reg ^ operand_reg;
                OP_RLC: begin
                    result_next = {operand_reg[DATA_W-2:0], c_reg};
                    c_next = operand_reg[DATA_W-1]; // see RQ5
                end
                OP_RRC: begin
                    result_next = {c_reg, operand_reg[DATA_W-1:1]};
                    c_next = operand_reg[0]; // see RQ5
                end
                OP_RLN: result_next = {operand_reg[DATA_W-2:0], operand_reg[DATA_W-1]};
                OP_RRN: result_next = {operand_reg[0], operand_reg[DATA_W-1:1]};
                OP_MOVWF: result_next = accumulator_reg;
                OP_MOVFW, OP_MOVFF: result_next = operand_reg; // see RQ9
                OP_MUL: prod_next = mul8(accumulator_reg, operand_reg); // see RQ8
                default: begin
                end
            endcase
            if (arith) begin
                // carry into bit 7 is sum7 ^ a7 ^ b7; compared with carry out
                ov_next = (sum[SIGN_BIT] ^ accumulator_reg[SIGN_BIT] ^ b_in[SIGN_BIT]) ^ sum[DATA_W]; // see RQ7, RQ20
            end
            if (arith || op_i == OP_AND || op_i == OP_IOR || op_i == OP_XOR) begin
                z_next = (result_next == {DATA_W{1'b0}}); // see RQ19, RQ5
            end
            wr_pend_next = (op_i != OP_NOP) && (op_i != OP_MUL);
        end
        if (phase_reg == PH_RESULT_WRITE && wr_pend_reg) begin
            // a write to the accumulator's own data location lands in the accumulator too
            if (op_i == OP_MOVFW || (op_i != OP_MOVFF && op_i != OP_MOVWF && dest_acc_i)
                || dst_addr_i == FADDR_W'(ACC_ADDR)) begin
                accumulator_next = result_reg; // see RQ4, RQ18
            end
            wr_pend_next = 1'b0;
        end
        if (srst_i) begin
            accumulator_next = ACC_RESET;
            operand_next = {DATA_W{1'b0}};
            result_next = {DATA_W{1'b0}};
            {c_next, dc_next, z_next, ov_next} = 4'h0;
            prod_next = {2*DATA_W{1'b0}};
            wr_pend_next = 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        accumulator_reg <= accumulator_next;
        operand_reg <= operand_next;
        result_reg <= result_next;
        c_reg <= c_next;
        dc_reg <= dc_next;
        z_reg <= z_next;
        ov_reg <= ov_next;
        prod_reg <= prod_next;
        wr_pend_reg <= wr_pend_next;
    end

    // file strobes are combinational handshakes on the phase
    always_comb begin
        file_rd_o = (phase_reg == PH_OPERAND_READ); // see RQ18
        file_addr_o = (phase_reg == PH_RESULT_WRITE) ? dst_addr_i : src_addr_i;
        file_we_o = (phase_reg == PH_RESULT_WRITE) && wr_pend_reg && (op_i != OP_MOVFW)
                    && ((op_i == OP_MOVFF) || (op_i == OP_MOVWF) || !dest_acc_i); // see RQ9
        file_wdata_o = result_reg;
    end

    // execution mode: mixed mode fetches above on-chip size externally and drops protection
    always_comb begin
        prog_ext_o = (exec_mode_i == MODE_EXTERNAL)
                     || (exec_mode_i == MODE_MIXED && pc_reg >= pmem_limit(pmem_size_i)); // see RQ13, RQ14
        protect_active_o = (exec_mode_i == MODE_PROTECTED)
                           || (code_protect_i && exec_mode_i == MODE_INTERNAL); // see RQ14
    end

    assign program_counter_o = pc_reg;
    assign accumulator_o = accumulator_reg;
    assign carry_flag_o = c_reg;
    assign nibble_carry_flag_o = dc_reg;
    assign zero_flag_o = z_reg;
    assign signed_overflow_flag_o = ov_reg;
    assign product_o = prod_reg;
    assign instr_o = ir_reg;
    assign phase_o = phase_reg;
endmodule

// file: asd_pkg.sv
// package for the alu status datapath: widths, phases, operation codes
package asd_pkg;
    localparam int DATA_W = 8;
    localparam int INSTR_W = 16;
    localparam int PADDR_W = 16;
    localparam int FADDR_W = 8;
    localparam int NIB_W = 4;
    localparam int PHASE_W = 2;
    localparam logic [PHASE_W-1:0] PH_FETCH_LATCH = 2'h0;
    localparam logic [PHASE_W-1:0] PH_OPERAND_READ = 2'h1;
    localparam logic [PHASE_W-1:0] PH_EXECUTE = 2'h2;
    localparam logic [PHASE_W-1:0] PH_RESULT_WRITE = 2'h3;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] PMEM_2K = 16'h0800;
    localparam logic [15:0] PMEM_4K = 16'h1000;
    localparam logic [15:0] PMEM_8K = 16'h2000;
    localparam int SIGN_BIT = 7;
    localparam int MAG_MSB = 6;

    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_ADD = 4'h1,
        OP_ADDC = 4'h2,
        OP_SUB = 4'h3,
        OP_SUBB = 4'h4,
        OP_AND = 4'h5,
        OP_IOR = 4'h6,
        OP_XOR = 4'h7,
        OP_RLC = 4'h8,
        OP_RRC = 4'h9,
        OP_RLN = 4'hA,
        OP_RRN = 4'hB,
        OP_MOVWF = 4'hC,
        OP_MOVFW = 4'hD,
        OP_MOVFF = 4'hE,
        OP_MUL = 4'hF
    } asd_op_type;

    typedef enum logic [1:0] {
        MODE_INTERNAL = 2'b00,
        MODE_PROTECTED = 2'b01,
        MODE_EXTERNAL = 2'b10,
        MODE_MIXED = 2'b11
    } asd_mode_type;

    typedef enum logic [1:0] {
        PM_2K = 2'b00,
        PM_4K = 2'b01,
        PM_8K = 2'b10
    } asd_pmsize_type;
endpackage

// file: asd_core_assertions.sv
// port-level checks of phase sequencing, file strobes and mode outputs
`timescale 1ns/100ps
module asd_core_checker
    import asd_pkg::*;
(
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic [1:0] exec_mode_i,
    input wire logic [3:0] op_i,
    input wire logic two_cycle_i,
    input wire logic [PADDR_W-1:0] branch_target_i,
    input wire logic [INSTR_W-1:0] prog_data_i,
    input wire logic [INSTR_W-1:0] instr_o,
    input wire logic [FADDR_W-1:0] src_addr_i,
    input wire logic [FADDR_W-1:0] dst_addr_i,
    input wire logic [FADDR_W-1:0] file_addr_o,
    input wire logic file_rd_o,
    input wire logic file_we_o,
    input wire logic prog_ext_o,
    input wire logic protect_active_o,
    input wire logic [PADDR_W-1:0] program_counter_o,
    input wire logic [DATA_W-1:0] accumulator_o,
    input wire logic [PHASE_W-1:0] phase_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    property p_phase; 1'b1 |=> phase_o == $past(phase_o) + 2'h1; endproperty
    a_phase: assert property (p_phase) else $error("phase did not advance");
    property p_read; file_rd_o == (phase_o == PH_OPERAND_READ); endproperty
    a_read: assert property (p_read) else $error("read strobe outside operand phase");
    property p_write; file_we_o |-> phase_o == PH_RESULT_WRITE; endproperty
    a_write: assert property (p_write) else $error("write strobe outside result phase");
    property p_src; file_rd_o |-> file_addr_o == src_addr_i; endproperty
    a_src: assert property (p_src) else $error("read address is not source");
    property p_dst; file_we_o |-> file_addr_o == dst_addr_i; endproperty
    a_dst: assert property (p_dst) else $error("write address is not destination");
    property p_mixed; exec_mode_i == MODE_MIXED |-> !protect_active_o; endproperty
    a_mixed: assert property (p_mixed) else $error("protection active in mixed mode");
    property p_ext; exec_mode_i == MODE_EXTERNAL |-> prog_ext_o; endproperty
    a_ext: assert property (p_ext) else $error("external mode fetches inside");
    property p_acc; phase_o != PH_RESULT_WRITE |=> $stable(accumulator_o); endproperty
    a_acc: assert property (p_acc) else $error("accumulator moved outside result phase");
    property p_count; phase_o == PH_FETCH_LATCH |=> program_counter_o == $past(program_counter_o) + 16'h0001;
    endproperty
    a_count: assert property (p_count) else $error("program counter did not step");
    property p_nowr; (op_i == OP_NOP || op_i == OP_MUL) |-> !file_we_o; endproperty
    a_nowr: assert property (p_nowr) else $error("file written by a non-writing op");
    property p_branch;
        (two_cycle_i && phase_o == PH_RESULT_WRITE) |=> program_counter_o == $past(branch_target_i);
    endproperty
    a_branch: assert property (p_branch) else $error("branch did not load the target");
    property p_flush; (two_cycle_i && phase_o == PH_RESULT_WRITE) |-> ##2 instr_o == 16'h0000; endproperty
    a_flush: assert property (p_flush) else $error("prefetched word not flushed");
    property p_fetch;
        (phase_o == PH_RESULT_WRITE && !two_cycle_i && dst_addr_i[7:1] != 7'h01)
            |-> ##2 instr_o == $past(prog_data_i, 2);
    endproperty
    a_fetch: assert property (p_fetch) else $error("instruction word not passed whole");
    property p_inside;
        (exec_mode_i == MODE_INTERNAL || exec_mode_i == MODE_PROTECTED
            || (exec_mode_i == MODE_MIXED && program_counter_o < PMEM_2K)) |-> !prog_ext_o;
    endproperty
    a_inside: assert property (p_inside) else $error("on-chip fetch went external");
    property p_above; (exec_mode_i == MODE_MIXED && program_counter_o >= PMEM_8K) |-> prog_ext_o; endproperty
    a_above: assert property (p_above) else $error("fetch above on-chip memory stayed inside");
    property p_prot; exec_mode_i == MODE_PROTECTED |-> protect_active_o; endproperty
    a_prot: assert property (p_prot) else $error("protected mode without protection");
    cover property (two_cycle_i && phase_o == PH_RESULT_WRITE);
    cover property (op_i == OP_MUL && phase_o == PH_RESULT_WRITE);
    cover property (file_we_o);
    cover property (exec_mode_i == MODE_MIXED);
endmodule

bind asd_core asd_core_checker chk_u (.mclk_i(mclk_i), .srst_i(srst_i), .exec_mode_i(exec_mode_i), .op_i(op_i),
    .two_cycle_i(two_cycle_i), .branch_target_i(branch_target_i), .prog_data_i(prog_data_i), .instr_o(instr_o),
    .src_addr_i(src_addr_i), .dst_addr_i(dst_addr_i), .file_addr_o(file_addr_o), .file_rd_o(file_rd_o),
    .file_we_o(file_we_o), .prog_ext_o(prog_ext_o), .protect_active_o(protect_active_o),
    .program_counter_o(program_counter_o), .accumulator_o(accumulator_o), .phase_o(phase_o));

// file: asd_regfile_model.sv
// behavioural register file on the far side of the datapath
`timescale 1ns/100ps
module asd_regfile_model
    import asd_pkg::*;
(
    input wire logic mclk_i,
    input wire logic [FADDR_W-1:0] file_addr_i,
    input wire logic file_rd_i,
    input wire logic file_we_i,
    input wire logic [DATA_W-1:0] file_wdata_i,
    output logic [DATA_W-1:0] file_rdata_o
);
    logic [DATA_W-1:0] mem [256];
    logic [DATA_W-1:0] last = 8'h00;
    initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hA5;
    always @(posedge mclk_i) begin
        if (file_we_i) mem[file_addr_i] <= file_wdata_i;
        if (file_rd_i) last <= mem[file_addr_i];
    end
    // off the read phase the bus shows the inverse, so a mistimed capture cannot pass
    assign file_rdata_o = file_rd_i ? mem[file_addr_i] : ~last;
endmodule

// file: alu_status_datapath_test.sv
// self-checking bench for the alu status datapath
`timescale 1ns/100ps
module alu_status_datapath_test;
    import asd_pkg::*;
    // accumulator's data location, as the core's default
    localparam logic [7:0] ACC_LOC = 8'h0A;
    typedef struct packed {logic [7:0] a; logic c, nib, z, ovf; logic [15:0] p; logic w; logic [7:0] wa, wd;} asd_exp_type;
    logic mclk_i = 1'b0, srst_i = 1'b1, code_protect_i = 1'b0, dest_acc_i = 1'b0, two_cycle_i = 1'b0;
    logic [15:0] branch_target_i = 16'h0000;
    logic [1:0] exec_mode_i = 2'h0, pmem_size_i = 2'h0, phase_o;
    logic [3:0] op_i = 4'h0;
    logic [7:0] src_addr_i = 8'h00, dst_addr_i = 8'h00, file_rdata_i, file_addr_o, file_wdata_o, accumulator_o;
    logic [15:0] prog_data_i = 16'h0000, program_counter_o, product_o, instr_o;
    logic prog_ext_o, protect_active_o, file_rd_o, file_we_o, cf, nf, zf, vf;
    logic [7:0] fm [256];
    logic [7:0] acc = 8'h00, wa = 8'h00, wd = 8'h00;
    logic c = 1'b0, nib = 1'b0, z = 1'b0, ovf = 1'b0, ws = 1'b0;
    logic [15:0] prod = 16'h0000;
    asd_exp_type q[$];
    asd_exp_type e, s;
    int error_cnt = 0;
    int n_checks = 0;
    always #4 mclk_i = ~mclk_i;
    asd_core dut_u (.mclk_i(mclk_i), .srst_i(srst_i), .exec_mode_i(exec_mode_i), .pmem_size_i(pmem_size_i),
        .code_protect_i(code_protect_i), .prog_data_i(prog_data_i), .program_counter_o(program_counter_o),
        .prog_ext_o(prog_ext_o), .protect_active_o(protect_active_o), .op_i(op_i), .src_addr_i(src_addr_i),
        .dst_addr_i(dst_addr_i), .dest_acc_i(dest_acc_i), .two_cycle_i(two_cycle_i), .branch_target_i(branch_target_i),
        .file_rdata_i(file_rdata_i), .file_addr_o(file_addr_o), .file_rd_o(file_rd_o), .file_we_o(file_we_o),
        .file_wdata_o(file_wdata_o), .accumulator_o(accumulator_o), .carry_flag_o(cf), .nibble_carry_flag_o(nf),
        .zero_flag_o(zf), .signed_overflow_flag_o(vf), .product_o(product_o), .instr_o(instr_o), .phase_o(phase_o));
    asd_regfile_model part_u (.mclk_i(mclk_i), .file_addr_i(file_addr_o), .file_rd_i(file_rd_o),
        .file_we_i(file_we_o), .file_wdata_i(file_wdata_o), .file_rdata_o(file_rdata_i));
    task automatic summarize();
        if (error_cnt == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // one whole instruction cycle, started at the edge that opens the fetch phase
    task automatic run(input asd_op_type op, input logic [7:0] sa, dd, input logic dacc);
        logic [7:0] f, b, res;
        logic [8:0] r;
        logic [4:0] n;
        logic ci;
        asd_exp_type x;
        int k;
        k = 0;
        do begin
            @(posedge mclk_i);
            k++;
        end while (phase_o !== PH_RESULT_WRITE && k < 10);
        if (k >= 10) begin
            error_cnt++;
            summarize();
        end
        op_i <= op;
        src_addr_i <= sa;
        dst_addr_i <= dd;
        dest_acc_i <= dacc;
        {exec_mode_i, code_protect_i} <= 3'($urandom);
        pmem_size_i <= 2'($urandom % 3);
        prog_data_i <= 16'($urandom);
        f = (sa == ACC_LOC) ? acc : fm[sa];
        b = (op == OP_SUB || op == OP_SUBB) ? ~f : f;
        ci = (op == OP_SUB) || ((op == OP_ADDC || op == OP_SUBB) && c);
        r = {1'b0, acc} + {1'b0, b} + 9'(ci);
        n = {1'b0, acc[3:0]} + {1'b0, b[3:0]} + 5'(ci);
        res = r[7:0];
        case (op)
            OP_ADD, OP_ADDC, OP_SUB, OP_SUBB: begin
                ovf = (acc[7] == b[7]) && (res[7] != acc[7]);
                c = r[8];
                nib = n[4];
                z = res == 8'h00;
            end
            OP_AND, OP_IOR, OP_XOR: begin
                res = op == OP_AND ? acc & f : op == OP_IOR ? acc | f : acc ^ f;
                z = res == 8'h00;
            end
            OP_RLC, OP_RRC: begin
                res = op == OP_RLC ? {f[6:0], c} : {c, f[7:1]};
                c = op == OP_RLC ? f[7] : f[0];
            end
            OP_RLN: res = {f[6:0], f[7]};
            OP_RRN: res = {f[0], f[7:1]};
            OP_MOVWF: res = acc;
            OP_MUL: prod = acc * f;
            default: res = f;
        endcase
        x = '0;
        if (op == OP_MOVWF || op == OP_MOVFF || (!dacc && op != OP_NOP && op != OP_MUL && op != OP_MOVFW)) begin
            fm[dd] = res;
            if (dd == ACC_LOC) acc = res;
            x.w = 1'b1;
            x.wa = dd;
            x.wd = res;
        end else if (op != OP_NOP && op != OP_MUL) acc = res;
        x.a = acc;
        {x.c, x.nib, x.z, x.ovf, x.p} = {c, nib, z, ovf, prod};
        repeat (3) @(posedge mclk_i);
        q.push_back(x);
    endtask
    always @(posedge mclk_i) begin
        if (file_we_o === 1'b1) begin
            ws = 1'b1;
            wa = file_addr_o;
            wd = file_wdata_o;
        end
    end
    // results of an instruction cycle are all settled once the next fetch phase opens
    always @(negedge mclk_i) begin
        if (srst_i === 1'b0 && phase_o === PH_FETCH_LATCH && q.size() > 0) begin
            e = q.pop_front();
            s = {accumulator_o, cf, nf, zf, vf, product_o, ws, wa, wd};
            n_checks++;
            if (s !== e) begin
                $display("mismatch result expected %h seen %h", e, s);
                error_cnt++;
            end
            {ws, wa, wd} = 17'h00000;
        end
    end
    initial begin
        asd_op_type op;
        for (int i = 0; i < 256; i++) fm[i] = 8'(i) ^ 8'hA5;
        void'($urandom(62461));
        repeat (6) @(posedge mclk_i);
        srst_i <= 1'b0;
        run(OP_NOP, 8'h10, 8'h10, 1'b1);
        run(OP_MOVFW, 8'h5A, 8'h5A, 1'b1);
        run(OP_ADD, ACC_LOC, ACC_LOC, 1'b0);
        run(OP_ADD, 8'hA4, 8'h30, 1'b1);
        run(OP_SUB, 8'hA4, 8'h31, 1'b0);
        run(OP_MOVFF, 8'h31, 8'h32, 1'b1);
        for (int o = 0; o < 16; o++) run(asd_op_type'(o), 8'h20 + 8'(o), 8'h40 + 8'(o), 1'(o));
        // branch above every on-chip size so mixed mode later fetches externally
        two_cycle_i <= 1'b1;
        branch_target_i <= 16'h2100;
        run(OP_NOP, 8'h10, 8'h10, 1'b1);
        two_cycle_i <= 1'b0;
        for (int i = 0; i < 400; i++) begin
            op = asd_op_type'($urandom % 16);
            run(op, 8'h10 + 8'($urandom % 240), 8'h10 + 8'($urandom % 240), op == OP_MOVFW || 1'($urandom));
        end
        repeat (8) @(posedge mclk_i);
        if (q.size() != 0) begin
            $display("mismatch pending results expected %0d seen %0d", 0, q.size());
            error_cnt++;
        end
        summarize();
    end
endmodule
